/* File: plmlc_core.sv */
// module: loop mode, lock detection and register file of the clock generator
//
// The APB register port and the address map were left to the implementer.
module plmlc_core
  import plmlc_pkg::*;
#(
  parameter int WINDOW = WINDOW_TICKS // reference ticks per lock measurement
) (
  input wire logic pclk, // bus clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W+1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic oscillator_enable_in, // oscillator enable from integration unit
  input wire logic crystal_clock, // crystal clock pin, sampled
  input wire logic vco_clock, // vco clock pin, sampled
  output logic crystal_run, // oscillator running
  output logic reference_tick, // one pulse per rising reference clock edge
  output logic vco_feedback_tick, // one pulse per N rising vco edges
  output logic loop_power_on, // loop powered
  output logic base_clock_select, // vco selected as base clock
  output plmlc_loop_state_t loop_state, // filter mode, lock and flag
  output logic [CENTER_W-1:0] vco_center_hz, // vco centre-of-range frequency
  output logic clock_generator_int // interrupt request, level
);

  localparam int CNT_W = $clog2(WINDOW) + 2;

  //----------------------------------------------------------------------
  // pin sampling
  //----------------------------------------------------------------------
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic osc_en;
  logic xtal_rise;
  logic vco_rise;

  plmlc_pin_sampler #(.WIDTH(3)) u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({vco_clock, crystal_clock, oscillator_enable_in}),
    .level(pin_level),
    .rise(pin_rise)
  );

  assign osc_en = pin_level[0];
  assign xtal_rise = pin_rise[1];
  assign vco_rise = pin_rise[2];

  //----------------------------------------------------------------------
  // register state
  //----------------------------------------------------------------------
  logic int_enable;
  logic lock_change_flag;
  logic base_sel;
  logic auto_bw;
  logic track_manual;
  logic [7:0] prog;
  logic [15:0] thresh;
  logic det_locked;
  logic det_tracking;

  logic [MUL_W-1:0] mul_n;
  logic [MUL_W-1:0] mul_l;
  logic [MUL_W-1:0] eff_n;
  logic l_zero;

  assign mul_n = prog[PROG_N_LSB +: MUL_W];
  assign mul_l = prog[0 +: MUL_W];
  assign eff_n = (mul_n == '0) ? MUL_W'(1) : mul_n;
  assign l_zero = (mul_l == '0);

  //----------------------------------------------------------------------
  // apb decode
  //----------------------------------------------------------------------
  logic [ADDR_W-1:0] idx;
  logic hit_ctrl;
  logic hit_bwc;
  logic hit_prog;
  logic hit_thresh;
  logic mapped;
  logic access;
  logic wr;
  logic rd_ctrl;
  logic [31:0] next_rdata;

  assign idx = paddr[ADDR_W+1:2];
  assign access = psel & penable;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_bwc = 1'b0;
    hit_prog = 1'b0;
    hit_thresh = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (idx == IDX_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (idx == IDX_BWC) begin
      hit_bwc = 1'b1;
    end else if (idx == IDX_PROG) begin
      hit_prog = 1'b1;
    end else if (idx == IDX_THRESH) begin
      hit_thresh = 1'b1;
    end
    mapped = hit_ctrl | hit_bwc | hit_prog | hit_thresh;
  end

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign wr = access & pwrite & mapped;
  assign rd_ctrl = access & ~pwrite & hit_ctrl;

  //----------------------------------------------------------------------
  // control register
  //----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable <= 1'b0;
    end else if (!auto_bw) begin
      int_enable <= 1'b0;
    end else if (wr && hit_ctrl) begin
      int_enable <= pwdata[CTRL_IE];
    end
  end

  // loop on may not change together with base select, and cannot clear
  // while the vco drives the base clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_power_on <= RST_CTRL_ON;
    end else if (wr && hit_ctrl && !base_sel && pwdata[CTRL_BCS] == 1'b0) begin
      loop_power_on <= pwdata[CTRL_ON];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_sel <= 1'b0;
    end else if (!loop_power_on || l_zero) begin
      base_sel <= 1'b0;
    end else if (wr && hit_ctrl && pwdata[CTRL_ON]) begin
      base_sel <= pwdata[CTRL_BCS];
    end
  end

  assign base_clock_select = base_sel;

  //----------------------------------------------------------------------
  // bandwidth and program registers
  //----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_bw <= 1'b0;
      track_manual <= 1'b0;
    end else if (wr && hit_bwc) begin
      auto_bw <= pwdata[BWC_AUTO];
      if (!auto_bw) begin
        track_manual <= pwdata[BWC_TRK];
      end
    end
  end

  // frozen while the loop runs so the divider never sees a mid-flight change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog <= RST_PROG;
    end else if (wr && hit_prog && !loop_power_on) begin
      prog <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh <= RST_THRESH;
    end else if (wr && hit_thresh) begin
      thresh <= pwdata[15:0];
    end
  end

  //----------------------------------------------------------------------
  // oscillator, reference and feedback divider
  //----------------------------------------------------------------------
  logic [MUL_W-1:0] div_cnt;

  assign crystal_run = osc_en;

  // reference is the crystal edge itself, undivided
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_tick <= 1'b0;
    end else begin
      reference_tick <= xtal_rise & osc_en;
    end
  end

  // modulo-N divider; sampling the vco at pclk only resolves slow vco rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      vco_feedback_tick <= 1'b0;
    end else if (!loop_power_on || !osc_en) begin
      div_cnt <= '0;
      vco_feedback_tick <= 1'b0;
    end else begin
      vco_feedback_tick <= 1'b0;
      if (vco_rise) begin
        if (div_cnt >= eff_n - MUL_W'(1)) begin
          div_cnt <= '0;
          vco_feedback_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + MUL_W'(1);
        end
      end
    end
  end

  //----------------------------------------------------------------------
  // lock detector
  //----------------------------------------------------------------------
  plmlc_det_state_t det_state;
  logic [CNT_W-1:0] ref_cnt;
  logic [CNT_W-1:0] fb_cnt;
  logic [CNT_W-1:0] diff;
  logic det_run;

  assign det_run = loop_power_on & osc_en & auto_bw;
  assign diff = (fb_cnt > CNT_W'(WINDOW)) ? fb_cnt - CNT_W'(WINDOW) :
                CNT_W'(WINDOW) - fb_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_state <= DET_IDLE;
      ref_cnt <= '0;
      fb_cnt <= '0;
    end else if (!det_run) begin
      det_state <= DET_IDLE;
      ref_cnt <= '0;
      fb_cnt <= '0;
    end else begin
      case (det_state)
        DET_IDLE: begin
          ref_cnt <= '0;
          fb_cnt <= '0;
          det_state <= DET_COUNT;
        end
        DET_COUNT: begin
          if (vco_feedback_tick && fb_cnt != '1) begin
            fb_cnt <= fb_cnt + CNT_W'(1);
          end
          if (reference_tick) begin
            ref_cnt <= ref_cnt + CNT_W'(1);
            if (ref_cnt == CNT_W'(WINDOW - 1)) begin
              det_state <= DET_JUDGE;
            end
          end
        end
        DET_JUDGE: begin
          det_state <= DET_IDLE;
        end
        default: begin
          det_state <= DET_IDLE;
        end
      endcase
    end
  end

  // separate entry and exit tolerances give hysteresis on both indicators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_locked <= 1'b0;
      det_tracking <= 1'b0;
    end else if (!det_run) begin
      det_locked <= 1'b0;
      det_tracking <= 1'b0;
    end else if (det_state == DET_JUDGE) begin
      if (diff <= CNT_W'(thresh[THR_LOCK_LSB +: TOL_W])) begin
        det_locked <= 1'b1;
      end else if (diff > CNT_W'(thresh[THR_UNLOCK_LSB +: TOL_W])) begin
        det_locked <= 1'b0;
      end
      if (diff <= CNT_W'(thresh[THR_TRK_LSB +: TOL_W])) begin
        det_tracking <= 1'b1;
      end else if (diff > CNT_W'(thresh[THR_UNTRK_LSB +: TOL_W])) begin
        det_tracking <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------
  // lock change flag and interrupt
  //----------------------------------------------------------------------
  logic locked_d;
  logic lock_toggle;
  logic flag_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_d <= 1'b0;
    end else begin
      locked_d <= det_locked;
    end
  end

  // only toggles made while in auto mode count; leaving auto drops lock quietly
  assign lock_toggle = (locked_d != det_locked) & auto_bw;
  // a read clears only the flag value it returned, so a new toggle survives
  assign flag_seen = rd_ctrl & prdata[CTRL_FLAG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_change_flag <= 1'b0;
    end else if (!auto_bw) begin
      lock_change_flag <= 1'b0;
    end else if (lock_toggle) begin
      lock_change_flag <= 1'b1;
    end else if (flag_seen) begin
      lock_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_generator_int <= 1'b0;
    end else begin
      clock_generator_int <= lock_change_flag & int_enable & auto_bw;
    end
  end

  //----------------------------------------------------------------------
  // mode outputs and centre frequency
  //----------------------------------------------------------------------
  logic tracking_now;

  assign tracking_now = auto_bw ? det_tracking : track_manual;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_state <= '0;
    end else begin
      loop_state.tracking <= tracking_now;
      loop_state.locked <= det_locked & auto_bw;
      loop_state.lock_change_flag <= lock_change_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_center_hz <= '0;
    end else begin
      vco_center_hz <= CENTER_W'(mul_l) * CENTER_W'(F_NOM_HZ);
    end
  end

  //----------------------------------------------------------------------
  // read data, captured in the setup cycle
  //----------------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (hit_ctrl) begin
      next_rdata[CTRL_IE] = int_enable & auto_bw;
      next_rdata[CTRL_FLAG] = lock_change_flag & auto_bw;
      next_rdata[CTRL_ON] = loop_power_on;
      next_rdata[CTRL_BCS] = base_sel;
      next_rdata[3:0] = CTRL_LOW_ONES;
    end else if (hit_bwc) begin
      next_rdata[BWC_AUTO] = auto_bw;
      next_rdata[BWC_LOCK] = det_locked & auto_bw;
      next_rdata[BWC_TRK] = tracking_now;
    end else if (hit_prog) begin
      next_rdata[7:0] = prog;
    end else if (hit_thresh) begin
      next_rdata[15:0] = thresh;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

endmodule // plmlc_core

/* File: plmlc_core_asserts.sv */
// checker: port-level properties of the clock generator control block
module plmlc_core_asserts
  import plmlc_pkg::*;
#(
  parameter int WINDOW = WINDOW_TICKS // reference ticks per measurement
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W+1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic oscillator_enable_in, // oscillator enable
  input wire logic crystal_clock, // crystal pin
  input wire logic vco_clock, // vco pin
  input wire logic crystal_run, // oscillator running
  input wire logic reference_tick, // reference pulse
  input wire logic vco_feedback_tick, // feedback pulse
  input wire logic loop_power_on, // loop on
  input wire logic base_clock_select, // vco as base clock
  input wire plmlc_loop_state_t loop_state, // mode, lock, flag
  input wire logic [CENTER_W-1:0] vco_center_hz, // centre frequency
  input wire logic clock_generator_int // interrupt request
);
  // ----------------------------------------------------------------
  // shadows of written fields, so outputs can be tied to their cause
  // ----------------------------------------------------------------
  logic wr_hit;
  logic auto_q;
  logic [7:0] prog_q;
  assign wr_hit = psel && penable && pwrite && pready && (paddr[1:0] == 2'b00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q <= 1'b0;
    end else if (wr_hit && paddr[ADDR_W+1:2] == IDX_BWC) begin
      auto_q <= pwdata[BWC_AUTO];
    end
  end
  // program writes only land while the loop is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_q <= RST_PROG;
    end else if (wr_hit && paddr[ADDR_W+1:2] == IDX_PROG && !loop_power_on) begin
      prog_q <= pwdata[7:0];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel |-> pready)
    else $error("ready low during a transfer");
  a_xtal_gated: assert property (!crystal_run [*3] |-> !reference_tick)
    else $error("reference tick while oscillator stopped");
  a_ref_pulse: assert property (reference_tick |=> !reference_tick)
    else $error("reference tick longer than one cycle");
  a_fb_gated: assert property ((!loop_power_on || !crystal_run) [*3] |-> !vco_feedback_tick)
    else $error("feedback tick while loop or oscillator off");
  a_center_track: assert property ($stable(prog_q) && $past(presetn) |->
    vco_center_hz == CENTER_W'(prog_q[3:0]) * CENTER_W'(F_NOM_HZ))
    else $error("centre frequency does not follow range multiplier");
  a_bcs_needs_on: assert property (base_clock_select |-> loop_power_on)
    else $error("base select set with loop off");
  a_lock_sets_flag: assert property ($rose(loop_state.locked) |=> loop_state.lock_change_flag)
    else $error("lock change did not raise flag");
  a_int_from_flag: assert property (clock_generator_int |-> loop_state.lock_change_flag)
    else $error("interrupt without flag");
  a_manual_quiet: assert property (!auto_q [*3] |-> !loop_state.locked &&
    !loop_state.lock_change_flag && !clock_generator_int)
    else $error("lock, flag or interrupt active in manual mode");
endmodule // plmlc_core_asserts

bind plmlc_core plmlc_core_asserts #(.WINDOW(WINDOW)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .oscillator_enable_in(oscillator_enable_in), .crystal_clock(crystal_clock),
  .vco_clock(vco_clock), .crystal_run(crystal_run), .reference_tick(reference_tick),
  .vco_feedback_tick(vco_feedback_tick), .loop_power_on(loop_power_on),
  .base_clock_select(base_clock_select), .loop_state(loop_state),
  .vco_center_hz(vco_center_hz), .clock_generator_int(clock_generator_int)
);

/* File: plmlc_pin_sampler.sv */
// module: two-flop synchroniser with rising-edge pulse for pin inputs
module plmlc_pin_sampler #(
  parameter int WIDTH = 1
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic [WIDTH-1:0] pin_in, // asynchronous pins
  output logic [WIDTH-1:0] level, // synchronised level
  output logic [WIDTH-1:0] rise // one-cycle pulse on each rising edge
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] last;

  // the first stage feeds the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      level <= '0;
    end else begin
      meta <= pin_in;
      level <= meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= '0;
    end else begin
      last <= level;
    end
  end

  assign rise = level & ~last;

endmodule // plmlc_pin_sampler

/* File: plmlc_pkg.sv */
// package: register map, field layout, reset values and detector types
//------------------------------------------------------------------------
// Contract
// - crystal oscillator and crystal clock run only while oscillator enable is high
// - reference clock is the crystal clock buffered, no division
// - vco clock divided modulo N gives the feedback clock
// - lock detector compares feedback and reference rates, decides mode and lock
// - tracking select reads zero in acquisition; tracking when not acquiring or bit set
// - with auto bandwidth set, detector switches acquisition and tracking itself
// - in auto mode tracking select is read-only filter mode; writes ignored
// - auto tracking sets inside tracking tolerance, clears outside untracking tolerance
// - auto lock sets inside lock tolerance, clears outside wider unlock tolerance
// - in auto mode each lock toggle raises interrupt when interrupt enable set
// - in manual mode tracking select is writable and picks the filter mode
// - manual mode disables the lock indicator and all interrupts
// - program register: N in upper four bits, L in lower four bits
// - vco centre frequency equals L times 4.9152 MHz
// - manual mode: flag and lock read zero, interrupt enable forced zero read-only
// - while loop is on the program register ignores writes
// - loop off or L zero forces base clock select to zero, read-only
// - programmed N of zero behaves exactly as one
//------------------------------------------------------------------------
package plmlc_pkg;

  //----------------------------------------------------------------------
  // register indices; byte address is four times the index
  //----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h1c;
  localparam logic [ADDR_W-1:0] IDX_BWC = 8'h1d;
  localparam logic [ADDR_W-1:0] IDX_PROG = 8'h1e;
  localparam logic [ADDR_W-1:0] IDX_THRESH = 8'h1f;

  // control register fields
  localparam int CTRL_IE = 7;
  localparam int CTRL_FLAG = 6;
  localparam int CTRL_ON = 5;
  localparam int CTRL_BCS = 4;
  localparam logic [3:0] CTRL_LOW_ONES = 4'hf;
  localparam logic RST_CTRL_ON = 1'h1;

  // bandwidth register fields
  localparam int BWC_AUTO = 7;
  localparam int BWC_LOCK = 6;
  localparam int BWC_TRK = 5;

  // program register fields and reset
  localparam int PROG_N_LSB = 4;
  localparam int MUL_W = 4;
  localparam logic [7:0] RST_PROG = 8'h66;

  // threshold register: four tolerance fields, each TOL_W bits
  localparam int TOL_W = 4;
  localparam int THR_LOCK_LSB = 0;
  localparam int THR_UNLOCK_LSB = 4;
  localparam int THR_TRK_LSB = 8;
  localparam int THR_UNTRK_LSB = 12;
  localparam logic [15:0] RST_THRESH = 16'h4221;

  //----------------------------------------------------------------------
  // timing and frequency constants
  //----------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int F_NOM_HZ = 4915200;
  localparam int CENTER_W = 27;
  localparam int WINDOW_TICKS = 32;

  //----------------------------------------------------------------------
  // types
  //----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DET_IDLE = 3'b001,
    DET_COUNT = 3'b010,
    DET_JUDGE = 3'b100
  } plmlc_det_state_t;

  typedef struct packed {
    logic tracking;
    logic locked;
    logic lock_change_flag;
  } plmlc_loop_state_t;

endpackage

/* File: test_pll_mode_and_lock_control.sv */
// testbench: registers, clock paths, lock detection and modes of the clock generator block
module test_pll_mode_and_lock_control
  import plmlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WIN = 4;
  localparam logic [ADDR_W+1:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W+1:0] A_BWC = {IDX_BWC, 2'b00};
  localparam logic [ADDR_W+1:0] A_PROG = {IDX_PROG, 2'b00};
  localparam logic [ADDR_W+1:0] A_THR = {IDX_THRESH, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W+1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic oscillator_enable_in = 1'b1;
  logic crystal_clock = 1'b0;
  logic vco_clock = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, crystal_run, reference_tick, vco_feedback_tick;
  logic loop_power_on, base_clock_select, clock_generator_int;
  plmlc_loop_state_t loop_state;
  logic [CENTER_W-1:0] vco_center_hz;
  logic [31:0] rd_v;
  logic err_v;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int xc = 0;
  int vc = 0;
  int vhalf = 4;
  int rt_n = 0;
  int fb_n = 0;

  plmlc_core #(.WINDOW(WIN)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscillator_enable_in(oscillator_enable_in), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .crystal_run(crystal_run), .reference_tick(reference_tick),
    .vco_feedback_tick(vco_feedback_tick), .loop_power_on(loop_power_on),
    .base_clock_select(base_clock_select), .loop_state(loop_state),
    .vco_center_hz(vco_center_hz), .clock_generator_int(clock_generator_int)
  );

  initial begin
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // pin clocks, tick counters and the hang limit
  // ----------------------------------------------------------------
  // crystal keeps toggling while disabled so the gating is really tested
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    rt_n <= rt_n + int'(reference_tick);
    fb_n <= fb_n + int'(vco_feedback_tick);
    if (xc == 3) begin
      xc <= 0;
      crystal_clock <= ~crystal_clock;
    end else begin
      xc <= xc + 1;
    end
    if (vhalf != 0) begin
      if (vc >= vhalf - 1) begin
        vc <= 0;
        vco_clock <= ~vco_clock;
      end else begin
        vc <= vc + 1;
      end
    end
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W+1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the global cycle limit ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [ADDR_W+1:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd_v, exp);
  endtask

  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (loop_state.locked !== v && n < 500) begin
      n++;
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    int a;
    int r0;
    int f0;
    logic [7:0] v;
    void'($urandom(99));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_CTRL, 32'h2f, "ctrl_reset");
    rdc(A_BWC, 32'h0, "bwc_reset");
    rdc(A_PROG, 32'h66, "prog_reset");
    rdc(A_THR, 32'h4221, "thresh_reset");
    rdc(10'h3fc, 32'h0, "unmapped");
    chk("unmapped_err", 32'(err_v), 32'h1);
    rdc(A_CTRL + 10'h1, 32'h0, "misaligned");
    chk("misaligned_err", 32'(err_v), 32'h1);
    chk("center_reset", 32'(vco_center_hz), 6 * F_NOM_HZ);
    $display("done: reset values");
    v = 8'($urandom);
    apb(1'b1, A_PROG, {24'h0, v});
    rdc(A_PROG, 32'h66, "prog_locked");
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_CTRL, 32'h10);
    rdc(A_CTRL, 32'h0f, "bcs_loop_off");
    for (a = 0; a < 4; a++) begin
      v = 8'($urandom);
      apb(1'b1, A_PROG, {24'h0, v});
      rdc(A_PROG, {24'h0, v}, "prog_rw");
      chk("center", 32'(vco_center_hz), v[3:0] * F_NOM_HZ);
    end
    $display("done: program register");
    apb(1'b1, A_PROG, 32'h27);
    apb(1'b1, A_CTRL, 32'h20);
    r0 = rt_n;
    f0 = fb_n;
    repeat (160) @(posedge pclk);
    chk("ref_rate", 32'(rt_n - r0 inside {[19:21]}), 32'h1);
    chk("fb_rate", 32'(fb_n - f0 inside {[9:11]}), 32'h1);
    oscillator_enable_in <= 1'b0;
    repeat (8) @(posedge pclk);
    r0 = rt_n;
    f0 = fb_n;
    repeat (80) @(posedge pclk);
    chk("osc_off_ticks", 32'(rt_n - r0 + fb_n - f0), 32'h0);
    chk("crystal_run", 32'(crystal_run), 32'h0);
    oscillator_enable_in <= 1'b1;
    $display("done: clock paths");
    // feedback divider of zero must count like one for the loop to lock
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_PROG, 32'h07);
    apb(1'b1, A_CTRL, 32'h20);
    apb(1'b1, A_BWC, 32'h80);
    apb(1'b1, A_BWC, 32'ha0);
    rdc(A_BWC, 32'h80, "acq_read_only");
    apb(1'b1, A_CTRL, 32'ha0);
    wait_lock(1'b1);
    chk("int_on_lock", 32'(clock_generator_int), 32'h1);
    rdc(A_CTRL, 32'hef, "flag_set");
    rdc(A_BWC, 32'he0, "auto_locked");
    repeat (2) @(posedge pclk);
    chk("flag_cleared", 32'(loop_state.lock_change_flag), 32'h0);
    vhalf <= 0;
    wait_lock(1'b0);
    chk("int_on_unlock", 32'(clock_generator_int), 32'h1);
    chk("trk_held", 32'(loop_state.tracking), 32'h1);
    apb(1'b1, A_THR, 32'h3221);
    repeat (80) @(posedge pclk);
    chk("trk_lost", 32'(loop_state.tracking), 32'h0);
    $display("done: automatic mode");
    vhalf <= 4;
    apb(1'b1, A_BWC, 32'h0);
    apb(1'b1, A_CTRL, 32'ha0);
    rdc(A_CTRL, 32'h2f, "manual_ctrl");
    repeat (100) @(posedge pclk);
    chk("manual_quiet", 32'({loop_state.locked, clock_generator_int}), 32'h0);
    rdc(A_BWC, 32'h0, "manual_bwc");
    apb(1'b1, A_BWC, 32'h20);
    rdc(A_BWC, 32'h20, "manual_trk");
    chk("trk_mode", 32'(loop_state.tracking), 32'h1);
    apb(1'b1, A_BWC, 32'h0);
    repeat (2) @(posedge pclk);
    chk("acq_mode", 32'(loop_state.tracking), 32'h0);
    apb(1'b1, A_CTRL, 32'h30);
    rdc(A_CTRL, 32'h3f, "bcs_on");
    chk("bcs_pin", 32'(base_clock_select), 32'h1);
    chk("loop_pin", 32'(loop_power_on), 32'h1);
    apb(1'b1, A_CTRL, 32'h20);
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_PROG, 32'h20);
    apb(1'b1, A_CTRL, 32'h20);
    apb(1'b1, A_CTRL, 32'h30);
    rdc(A_CTRL, 32'h2f, "bcs_l_zero");
    $display("done: manual mode");
    test_done();
  end
endmodule // test_pll_mode_and_lock_control
